// ### verilog/lintc_ctrl.sv
// Summary of operation
// - off mode after reset, selectable in every chip mode except fail-safe, stops the bus
// - off mode ignores bus wake events
// - normal mode selectable only in chip normal or stop
// - early dominant is dropped; only the next dominant after recessive is sent
// - receive-only disables driver, keeps receiver; chip normal or stop only
// - wake-capable selectable in stop, sleep, restart, normal; forced in fail-safe
// - wake: falling edge, dominant beyond filter time, then rising edge
// - after wake, receive output low until another mode is chosen
// - after wake mode field stays wake-capable, no new wake until rearmed
// - rearm by switching to another mode then back to wake-capable
// - rearm automatically on entry to stop, sleep or fail-safe
// - wake in stop or normal raises interrupt and status bit, mode kept
// - wake in stop enables watchdog if watchdog-on-bus-wake was set
// - wake in sleep or fail-safe goes to restart; no interrupt there
// - tx dominant beyond timeout disables driver and sets fault flag
// - driver returns once tx input is no longer dominant
// - bus dominant beyond timeout in normal or receive-only sets fault
// - supply undervoltage disables driver and receiver, config kept
// - normal slope default; low-slope bit applies on select release
// - slope bit written only in chip normal mode
// - slope-bypass bit in chip normal, applies on select release
// - wake filter time lies between 30 and 150 microseconds
//
// one transceiver channel's control logic
// assumes pin inputs asynchronous; chip mode and config from same clock
`timescale 1ns/1ps
`include "lintc_regs.svh"

module lintc_ctrl #(
    parameter int TX_TO_CYC = `LINTC_TX_TO_DEF,
    parameter int BUS_TO_CYC = `LINTC_BUS_TO_DEF,
    parameter int EN_CYC = `LINTC_EN_TIME_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire lintc_pkg::lintc_chip_e chip_mode,
    input wire lintc_pkg::lintc_cfg_s cfg,
    input wire logic spi_select_n,
    input wire logic watchdog_on_bus_wake,
    input wire logic watchdog_enabled,
    input wire logic supply_uv,
    input wire logic bus_tx_in,
    input wire logic bus_rx_level,
    input wire logic fault_clear,
    output logic bus_drive_dom,
    output logic driver_en,
    output logic receiver_en,
    output logic bus_rx_out,
    output logic [1:0] channel_a_mode_field,
    output logic channel_a_fault_flag,
    output logic bus_wake_status,
    output logic low_slope_select,
    output logic slope_bypass,
    output lintc_pkg::lintc_wake_s wake_out
);
    import lintc_pkg::*;

    localparam int CW = `LINTC_CNT_W;
    localparam logic [CW-1:0] WK_CYC = CW'(`LINTC_WAKE_FILT_CYC);
    localparam logic [CW-1:0] TX_TO = CW'(TX_TO_CYC);
    localparam logic [CW-1:0] BUS_TO = CW'(BUS_TO_CYC);
    localparam logic [CW-1:0] EN_T = CW'(EN_CYC);

    // three-stage synchronisers for pins
    logic [2:0] tx_sync;
    logic [2:0] rx_sync;
    logic [2:0] uv_sync;
    logic tx_dom;
    logic bus_dom;
    logic uv;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_sync <= 3'h7;
            rx_sync <= 3'h7;
            uv_sync <= 3'h0;
        end else begin
            tx_sync <= {tx_sync[1:0], bus_tx_in};
            rx_sync <= {rx_sync[1:0], bus_rx_level};
            uv_sync <= {uv_sync[1:0], supply_uv};
        end
    end
    // accepted levels change once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_dom <= 1'b0;
            bus_dom <= 1'b0;
            uv <= 1'b0;
        end else begin
            if (tx_sync[1] == tx_sync[2]) tx_dom <= ~tx_sync[2];
            if (rx_sync[1] == rx_sync[2]) bus_dom <= ~rx_sync[2];
            if (uv_sync[1] == uv_sync[2]) uv <= uv_sync[2];
        end
    end

    // chip mode history
    lintc_chip_e chip_prev;
    logic chip_enter_rearm;
    always_ff @(posedge clk) begin
        if (!rstn) chip_prev <= LINTC_CHIP_INIT;
        else chip_prev <= chip_mode;
    end
    // rearm on entering stop, sleep or fail-safe
    assign chip_enter_rearm = (chip_mode != chip_prev) &&
        (chip_mode == LINTC_CHIP_STOP || chip_mode == LINTC_CHIP_SLEEP ||
         chip_mode == LINTC_CHIP_FAILSAFE);

    // spi writes take effect on select release
    logic sel_d;
    logic sel_rise;
    always_ff @(posedge clk) begin
        if (!rstn) sel_d <= 1'b1;
        else sel_d <= spi_select_n;
    end
    assign sel_rise = spi_select_n && !sel_d;

    logic chip_norm_stop;
    logic wake_allowed;
    assign chip_norm_stop = (chip_mode == LINTC_CHIP_NORMAL) || (chip_mode == LINTC_CHIP_STOP);
    assign wake_allowed = chip_norm_stop || chip_mode == LINTC_CHIP_SLEEP ||
        chip_mode == LINTC_CHIP_RESTART;

    // mode field selection
    logic [1:0] mode;
    logic [1:0] next_mode;
    always_comb begin
        next_mode = mode;
        if (chip_mode == LINTC_CHIP_FAILSAFE) begin
            next_mode = `LINTC_MODE_WAKE;
        end else if (sel_rise && cfg.mode_wr) begin
            case (cfg.mode)
                `LINTC_MODE_OFF: next_mode = `LINTC_MODE_OFF;
                // normal only in chip normal or stop
                `LINTC_MODE_NORM: if (chip_norm_stop) next_mode = `LINTC_MODE_NORM;
                // receive-only in chip normal or stop
                `LINTC_MODE_RXO: if (chip_norm_stop) next_mode = `LINTC_MODE_RXO;
                // wake-capable in the four chip modes
                default: if (wake_allowed) next_mode = `LINTC_MODE_WAKE;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) mode <= `LINTC_MODE_OFF;
        else mode <= next_mode;
    end

    // wake detector states
    typedef enum logic [1:0] {
        LINTC_WK_IDLE = 2'b00,
        LINTC_WK_DOM = 2'b01,
        LINTC_WK_DONE = 2'b10
    } lintc_wk_e;
    lintc_wk_e wk_state;
    logic [CW-1:0] wk_cnt;
    logic armed;
    logic woken;
    logic wake_evt;
    logic bus_dom_d;
    logic leave_wake;
    assign leave_wake = (mode == `LINTC_MODE_WAKE) && (next_mode != `LINTC_MODE_WAKE);
    assign wake_evt = (mode == `LINTC_MODE_WAKE) && armed && !uv &&
        wk_state == LINTC_WK_DONE && !bus_dom;

    always_ff @(posedge clk) begin
        if (!rstn) bus_dom_d <= 1'b0;
        else bus_dom_d <= bus_dom;
    end
    // falling edge, filtered dominant, rising edge
    always_ff @(posedge clk) begin
        if (!rstn || mode != `LINTC_MODE_WAKE || !armed) begin
            wk_state <= LINTC_WK_IDLE;
            wk_cnt <= '0;
        end else begin
            case (wk_state)
                LINTC_WK_IDLE: begin
                    wk_cnt <= '0;
                    if (bus_dom && !bus_dom_d) wk_state <= LINTC_WK_DOM;
                end
                LINTC_WK_DOM: begin
                    if (!bus_dom) wk_state <= LINTC_WK_IDLE;
                    else if (wk_cnt >= WK_CYC) wk_state <= LINTC_WK_DONE;
                    else wk_cnt <= wk_cnt + 1'b1;
                end
                LINTC_WK_DONE: if (!bus_dom) wk_state <= LINTC_WK_IDLE;
                default: wk_state <= LINTC_WK_IDLE;
            endcase
        end
    end
    // one wake per arming; rearm on leaving wake mode
    always_ff @(posedge clk) begin
        if (!rstn) armed <= 1'b1;
        else if (wake_evt) armed <= 1'b0;
        else if (leave_wake || chip_enter_rearm) armed <= 1'b1;
    end
    // woken holds rx low until another mode
    always_ff @(posedge clk) begin
        if (!rstn) woken <= 1'b0;
        else if (wake_evt) woken <= 1'b1;
        else if (next_mode != `LINTC_MODE_WAKE) woken <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wake_out <= '0;
        end else begin
            wake_out.int_req <= wake_evt && chip_norm_stop;
            wake_out.to_restart <= wake_evt && (chip_mode == LINTC_CHIP_SLEEP ||
                chip_mode == LINTC_CHIP_FAILSAFE);
            wake_out.wd_enable <= wake_evt && chip_mode == LINTC_CHIP_STOP &&
                watchdog_on_bus_wake && !watchdog_enabled;
        end
    end
    // sticky wake status, set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) bus_wake_status <= 1'b0;
        else if (wake_evt) bus_wake_status <= 1'b1;
        else if (fault_clear) bus_wake_status <= 1'b0;
    end

    // enabling time and blocked-dominant tracking
    logic active;
    logic [CW-1:0] en_cnt;
    logic en_done;
    logic tx_block;
    assign active = (mode == `LINTC_MODE_NORM);
    always_ff @(posedge clk) begin
        if (!rstn || !active) en_cnt <= '0;
        else if (!en_done) en_cnt <= en_cnt + 1'b1;
    end
    assign en_done = (en_cnt >= EN_T);
    // early dominant blocked until tx goes recessive after enabling
    always_ff @(posedge clk) begin
        if (!rstn || !active) tx_block <= 1'b1;
        else if (en_done && !tx_dom) tx_block <= 1'b0;
    end

    // tx dominant timeout
    logic [CW-1:0] txto_cnt;
    logic tx_timeout;
    // count dominant tx; release when tx recessive
    always_ff @(posedge clk) begin
        if (!rstn || !tx_dom) begin
            txto_cnt <= '0;
            tx_timeout <= 1'b0;
        end else if (txto_cnt >= TX_TO) begin
            tx_timeout <= 1'b1;
        end else begin
            txto_cnt <= txto_cnt + 1'b1;
        end
    end
    // bus dominant clamp timeout
    logic [CW-1:0] busto_cnt;
    logic bus_clamp;
    logic listen;
    assign listen = active || mode == `LINTC_MODE_RXO;
    // bus clamp in normal or receive-only
    always_ff @(posedge clk) begin
        if (!rstn || !bus_dom || !listen) begin
            busto_cnt <= '0;
            bus_clamp <= 1'b0;
        end else if (busto_cnt >= BUS_TO) begin
            bus_clamp <= 1'b1;
        end else begin
            busto_cnt <= busto_cnt + 1'b1;
        end
    end
    // sticky fault flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) channel_a_fault_flag <= 1'b0;
        else if ((tx_timeout && active) || bus_clamp) channel_a_fault_flag <= 1'b1;
        else if (fault_clear) channel_a_fault_flag <= 1'b0;
    end

    // slope settings on select release in chip normal
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_slope_select <= 1'b0;
            slope_bypass <= 1'b0;
        end else if (sel_rise && chip_mode == LINTC_CHIP_NORMAL) begin
            if (cfg.slope_wr) low_slope_select <= cfg.low_slope_select;
            if (cfg.flash_wr) slope_bypass <= cfg.flash_select;
        end
    end

    // pin-side outputs
    logic drv;
    // driver only in normal mode, no tx timeout, no undervoltage
    assign drv = active && !tx_timeout && !uv;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            driver_en <= 1'b0;
            receiver_en <= 1'b0;
            bus_drive_dom <= 1'b0;
            bus_rx_out <= 1'b1;
            channel_a_mode_field <= `LINTC_MODE_OFF;
        end else begin
            driver_en <= drv;
            receiver_en <= listen && !uv;
            // dominant sent only when not blocked
            bus_drive_dom <= drv && tx_dom && !tx_block;
            // rx low after wake, else bus level while listening
            bus_rx_out <= woken ? 1'b0 : !(listen && !uv && bus_dom);
            channel_a_mode_field <= next_mode;
        end
    end

    // checks
    mode_reset_a: assert property (@(posedge clk) !rstn |=> channel_a_mode_field == `LINTC_MODE_OFF)
        else $error("mode not off after reset");
    off_nowake_a: assert property (@(posedge clk) disable iff (!rstn)
        mode == `LINTC_MODE_OFF |-> !wake_evt)
        else $error("wake in off mode");
    norm_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (next_mode == `LINTC_MODE_NORM && mode != `LINTC_MODE_NORM) |-> chip_norm_stop)
        else $error("normal mode entered in wrong chip mode");
    rxo_drv_a: assert property (@(posedge clk) disable iff (!rstn)
        mode == `LINTC_MODE_RXO |=> !driver_en)
        else $error("driver on in receive-only");
    wake_rx_a: assert property (@(posedge clk) disable iff (!rstn)
        wake_evt |=> ##1 (!bus_rx_out) [*2])
        else $error("rx not low after wake");
    wake_once_a: assert property (@(posedge clk) disable iff (!rstn)
        wake_evt |=> !wake_evt)
        else $error("second wake without rearm");
    tx_to_drv_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_timeout |=> !driver_en)
        else $error("driver on after tx timeout");
    uv_off_a: assert property (@(posedge clk) disable iff (!rstn)
        uv |=> !driver_en && !receiver_en)
        else $error("stages on under undervoltage");
    slope_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        chip_mode != LINTC_CHIP_NORMAL |=> $stable(low_slope_select))
        else $error("slope changed outside chip normal");
    fs_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        chip_mode == LINTC_CHIP_FAILSAFE |=> channel_a_mode_field == `LINTC_MODE_WAKE)
        else $error("fail-safe did not force wake mode");
    wake_seen_c: cover property (@(posedge clk) disable iff (!rstn) wake_evt);
    tx_to_c: cover property (@(posedge clk) disable iff (!rstn) tx_timeout);
    clamp_c: cover property (@(posedge clk) disable iff (!rstn) bus_clamp);
endmodule // lintc_ctrl

// ### verilog/lintc_regs.svh
// constants for the bus transceiver mode control block
// assumes a 40 MHz clock (25 ns period)
`ifndef LINTC_REGS_SVH
`define LINTC_REGS_SVH
// clock period in picoseconds
`define LINTC_CLK_PERIOD_PS 25000
// wake filter window in microseconds, min and max
`define LINTC_WAKE_FILT_MIN_US 30
`define LINTC_WAKE_FILT_MAX_US 150
// wake filter count, min rounded up to whole cycles
`define LINTC_WAKE_FILT_CYC ((`LINTC_WAKE_FILT_MIN_US * 1000000 + `LINTC_CLK_PERIOD_PS - 1) / `LINTC_CLK_PERIOD_PS)
// default timing counts in cycles (not documented, plain defaults)
`define LINTC_TX_TO_DEF 80000
`define LINTC_BUS_TO_DEF 80000
`define LINTC_EN_TIME_DEF 400
// counter width
`define LINTC_CNT_W 20
// mode field encodings
`define LINTC_MODE_OFF 2'h0
`define LINTC_MODE_WAKE 2'h1
`define LINTC_MODE_RXO 2'h2
`define LINTC_MODE_NORM 2'h3
`endif

// ### verilog/lintc_pkg.sv
// types for the bus transceiver mode control block
// assumes lintc_regs.svh constants for encodings
package lintc_pkg;
    // chip operating mode
    typedef enum logic [2:0] {
        LINTC_CHIP_INIT = 3'b000,
        LINTC_CHIP_NORMAL = 3'b001,
        LINTC_CHIP_STOP = 3'b010,
        LINTC_CHIP_SLEEP = 3'b011,
        LINTC_CHIP_RESTART = 3'b100,
        LINTC_CHIP_FAILSAFE = 3'b101
    } lintc_chip_e;
    // spi write of one channel's settings, applied on select release
    typedef struct packed {
        logic mode_wr;
        logic [1:0] mode;
        logic slope_wr;
        logic low_slope_select;
        logic flash_wr;
        logic flash_select;
    } lintc_cfg_s;
    // wake report to the chip state logic
    typedef struct packed {
        logic int_req;
        logic to_restart;
        logic wd_enable;
    } lintc_wake_s;
endpackage

// ### testbench/lintc_partner.sv
// far side model: controller transmit pin and the single-wire bus
// assumes the bench commands dominant levels; the bus line has a pull-up
`timescale 1ns/1ps

module lintc_partner #(
    parameter int EN_CYC = 10
) (
    input wire logic clk,
    input wire logic tx_dom_req,
    input wire logic early_tx,
    input wire logic far_dom,
    input wire logic bus_drive_dom,
    input wire logic driver_en,
    output logic bus_tx_in,
    output logic bus_rx_level
);
    int en_cnt;

    // cycles since the driver came up, plus margin for pin sync
    always_ff @(posedge clk) begin
        if (!driver_en) begin
            en_cnt <= 0;
        end else if (en_cnt < EN_CYC + 8) begin
            en_cnt <= en_cnt + 1;
        end
    end

    // hold tx recessive while enabling, unless told to misbehave
    assign bus_tx_in = ~(tx_dom_req && (early_tx || en_cnt >= EN_CYC + 8));
    // wired bus with pull-up: dominant when either node pulls low
    assign bus_rx_level = ~(far_dom || (driver_en && bus_drive_dom));
endmodule // lintc_partner

// ### testbench/lin_transceiver_mode_control_tb_top.sv
// self-checking bench for the bus transceiver mode control block
// assumes lintc_partner on the far side and one 40 MHz clock
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module lin_transceiver_mode_control_tb_top;
    import lintc_pkg::*;
    localparam int EN = 10;
    logic clk = 1'h0, rstn = 1'h0, sel_n = 1'h1, wd_bw = 1'h1, wd_en = 1'h0;
    logic uv = 1'h0, fclr = 1'h0, tx_dom = 1'h0, early = 1'h0, far_dom = 1'h0, rb;
    lintc_chip_e chip = LINTC_CHIP_INIT;
    lintc_cfg_s cfg = '0;
    logic bus_tx_in, bus_rx_level, drv_dom, drv_en, rx_en, rx_out, flag, wk_st, ls, byp;
    logic [1:0] field;
    lintc_wake_s wk, e_w;
    lintc_wake_s exp_q[$];
    int n_errors = 0, cmp_count = 0, cyc = 0;

    lintc_ctrl #(.TX_TO_CYC(50), .BUS_TO_CYC(50), .EN_CYC(EN)) uut (
        .clk(clk), .rstn(rstn), .chip_mode(chip), .cfg(cfg), .spi_select_n(sel_n),
        .watchdog_on_bus_wake(wd_bw), .watchdog_enabled(wd_en), .supply_uv(uv),
        .bus_tx_in(bus_tx_in), .bus_rx_level(bus_rx_level), .fault_clear(fclr),
        .bus_drive_dom(drv_dom), .driver_en(drv_en), .receiver_en(rx_en),
        .bus_rx_out(rx_out), .channel_a_mode_field(field), .channel_a_fault_flag(flag),
        .bus_wake_status(wk_st), .low_slope_select(ls), .slope_bypass(byp), .wake_out(wk)
    );

    lintc_partner #(.EN_CYC(EN)) far (
        .clk(clk), .tx_dom_req(tx_dom), .early_tx(early), .far_dom(far_dom),
        .bus_drive_dom(drv_dom), .driver_en(drv_en), .bus_tx_in(bus_tx_in),
        .bus_rx_level(bus_rx_level)
    );

    // clock generator
    always #12.5 clk = ~clk;

    // result watcher: each wake pulse takes the oldest note
    always @(posedge clk) begin
        if (rstn && wk !== '0) begin
            if (exp_q.size() == 0) begin
                `CHK(wk, 3'h0)
            end else begin
                e_w = exp_q.pop_front();
                `CHK(wk, e_w)
            end
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one select low period carrying a settings write
    task automatic wr(input logic mw, input logic [1:0] m, input logic sw, input logic sv,
            input logic fw, input logic fv);
        @(posedge clk);
        cfg <= '{mw, m, sw, sv, fw, fv};
        sel_n <= 1'h0;
        @(posedge clk);
        sel_n <= 1'h1;
        tick(3);
        cfg <= '0;
    endtask

    task automatic wrmode(input logic [1:0] m);
        wr(1'h1, m, 1'h0, 1'h0, 1'h0, 1'h0);
    endtask

    // far node holds the bus dominant for n cycles
    task automatic dom(input int n);
        far_dom <= 1'h1;
        tick(n);
        far_dom <= 1'h0;
        tick(20);
    endtask

    task automatic set_chip(input lintc_chip_e c);
        chip <= c;
        tick(4);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    function automatic logic [1:0] exp_mode(input lintc_chip_e c, input logic [1:0] m);
        if (c == LINTC_CHIP_FAILSAFE) return 2'h1;
        if (m == 2'h0) return 2'h0;
        if (m == 2'h1) return (c == LINTC_CHIP_INIT) ? 2'h0 : 2'h1;
        return (c == LINTC_CHIP_NORMAL || c == LINTC_CHIP_STOP) ? m : 2'h0;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h6a64));
        tick(12);
        rstn <= 1'h1;
        tick(2);
        `CHK({field, drv_en, rx_out, flag}, 5'h2)
        `CHK({ls, byp}, 2'h0)
        done("reset");
        for (int c = 0; c < 6; c++) begin
            for (int m = 0; m < 4; m++) begin
                set_chip(lintc_chip_e'(c));
                wrmode(2'h0);
                wrmode(2'(m));
                `CHK(field, exp_mode(lintc_chip_e'(c), 2'(m)))
            end
        end
        done("mode table");
        rb = 1'($urandom % 2);
        set_chip(LINTC_CHIP_STOP);
        wr(1'h0, 2'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        `CHK({ls, byp}, 2'h0)
        set_chip(LINTC_CHIP_NORMAL);
        wr(1'h0, 2'h0, 1'h1, rb, 1'h1, ~rb);
        `CHK({ls, byp}, {rb, ~rb})
        done("slope");
        wrmode(2'h2);
        tick(8);
        `CHK({drv_en, rx_en}, 2'h1)
        far_dom <= 1'h1;
        tick(8);
        `CHK(rx_out, 1'h0)
        far_dom <= 1'h0;
        wrmode(2'h0);
        done("receive only");
        early <= 1'h1;
        tx_dom <= 1'h1;
        wrmode(2'h3);
        tick(20);
        `CHK(drv_dom, 1'h0)
        tx_dom <= 1'h0;
        tick(6);
        tx_dom <= 1'h1;
        tick(8);
        `CHK(drv_dom, 1'h1)
        tx_dom <= 1'h0;
        early <= 1'h0;
        done("enabling");
        tick(6);
        tx_dom <= 1'h1;
        tick(80);
        `CHK({flag, drv_dom, field}, 4'hB)
        tx_dom <= 1'h0;
        tick(8);
        tx_dom <= 1'h1;
        tick(25);
        `CHK(drv_dom, 1'h1)
        tx_dom <= 1'h0;
        fclr <= 1'h1;
        tick(8);
        fclr <= 1'h0;
        tick(2);
        `CHK(flag, 1'h0)
        far_dom <= 1'h1;
        tick(80);
        `CHK({flag, field}, 3'h7)
        far_dom <= 1'h0;
        done("timeouts");
        tick(8);
        uv <= 1'h1;
        tick(8);
        `CHK({drv_en, rx_en}, 2'h0)
        uv <= 1'h0;
        tick(8);
        `CHK({drv_en, rx_en, field}, 4'hF)
        done("undervoltage");
        set_chip(LINTC_CHIP_STOP);
        wrmode(2'h1);
        dom(600 + int'($urandom % 400));
        `CHK(rx_out, 1'h1)
        exp_q.push_back('{1'h1, 1'h0, 1'h1});
        dom(1250 + int'($urandom % 100));
        `CHK({rx_out, wk_st, field}, 4'h5)
        dom(1300);
        `CHK(field, 2'h1)
        set_chip(LINTC_CHIP_SLEEP);
        exp_q.push_back('{1'h0, 1'h1, 1'h0});
        dom(1300);
        `CHK(rx_out, 1'h0)
        set_chip(LINTC_CHIP_RESTART);
        wrmode(2'h0);
        `CHK(rx_out, 1'h1)
        dom(1300);
        wrmode(2'h1);
        // wake in restart stays in restart: no pulse, so no note
        dom(1300);
        `CHK(rx_out, 1'h0)
        set_chip(LINTC_CHIP_FAILSAFE);
        exp_q.push_back('{1'h0, 1'h1, 1'h0});
        dom(1300);
        `CHK(exp_q.size(), 0)
        done("wake");
        results();
    end
endmodule // lin_transceiver_mode_control_tb_top
